// file: verilog/sie_core.sv
`timescale 1ns/1ps
module sie_core (
  input wire logic clk, // core clock
  input wire logic sys_rst, // async reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [7:0] wb_adr_i, // bus byte address
  input wire logic [3:0] wb_sel_i, // bus byte enables
  input wire logic [31:0] wb_dat_i, // bus write data
  output logic [31:0] wb_dat_o, // bus read data
  output logic wb_ack_o, // bus acknowledge
  output sie_pkg::sie_mem_req_t mem_req, // stack memory request
  input wire logic [31:0] mem_rdata, // stack memory read data
  input wire logic mem_ack, // stack memory acknowledge
  input wire logic [sie_pkg::NUM_IRQ-1:0] irq_in, // maskable irq events
  input wire logic nmi_in, // nonmaskable irq event
  output logic irq_o // event interrupt
);
  import sie_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sie_state_t state;
  sie_op_t op_q;
  logic [3:0] idx_q;
  logic entry_q;
  logic [31:0] vec_q;
  logic [31:0] stp;
  logic [31:0] vtp;
  logic [31:0] pc;
  logic global_irq_enable, cache_freeze, prior_global_irq_enable, prior_cache_freeze;
  logic [NUM_IRQ-1:0] flag, irq_en;
  logic nmi_pend;
  logic cmd_pend;
  logic [31:0] cmd_q, arg;
  logic [31:0] aux_ea;
  logic [2:0] int_stat, int_mask;
  logic [39:0] ext [NUM_EXT];
  logic [31:0] aux [NUM_AUX];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic bus_wr, idle, take_irq, take_cmd, wr_done, rd_done, vec_done;
  logic cmd_push, cmd_pop, cmd_bad, reject;
  logic [NUM_IRQ-1:0] live, irq_clr;
  logic irq_any;
  logic [31:0] next_vec;
  sie_op_t cmd_op;
  logic [3:0] cmd_idx;
  sie_amode_t cmd_mode;
  logic [2:0] cmd_aux;
  logic [31:0] disp;

  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign idle = (state == ST_IDLE);
  assign live = flag & irq_en;
  assign irq_any = nmi_pend | (global_irq_enable & (|live));
  assign take_irq = idle & irq_any;
  assign take_cmd = idle & ~irq_any & cmd_pend;
  assign wr_done = (state == ST_WR) & mem_ack;
  assign rd_done = (state == ST_RD) & mem_ack;
  assign vec_done = (state == ST_VEC) & mem_ack;
  assign cmd_op = sie_op_t'(cmd_q[3:0]);
  assign cmd_idx = cmd_q[7:4];
  assign cmd_mode = sie_amode_t'(cmd_q[10:9]);
  assign cmd_aux = cmd_q[14:12];
  assign disp = {24'h00_0000, cmd_q[23:16]};
  assign cmd_bad = ((cmd_op == OP_PUSH_INT) | (cmd_op == OP_PUSH_FLT) |
                    (cmd_op == OP_POP_INT) | (cmd_op == OP_POP_FLT)) & (cmd_idx > EXT_LAST);
  assign cmd_push = ~cmd_bad & ((cmd_op == OP_PUSH_INT) | (cmd_op == OP_PUSH_FLT) |
                                (cmd_op == OP_CALL));
  assign cmd_pop = ~cmd_bad & ((cmd_op == OP_POP_INT) | (cmd_op == OP_POP_FLT) |
                               (cmd_op == OP_RET) | ((cmd_op == OP_RETI) & cmd_q[CMD_COND]));
  assign reject = bus_wr & (wb_adr_i == A_CMD) & (cmd_pend | ~idle);

  // nonmaskable first, then the lowest enabled flag
  always_comb begin
    next_vec = VEC_NMI;
    irq_clr = '0;
    if (!nmi_pend) begin
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
        if (live[i]) begin
          next_vec = VEC_IRQ_BASE + 32'(i);
          irq_clr = NUM_IRQ'(1) << i;
        end
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequencer and stack memory request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      mem_req <= '0;
      op_q <= OP_NONE;
      idx_q <= 4'h0;
      entry_q <= 1'b0;
      vec_q <= 32'h0000_0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_irq) begin
            entry_q <= 1'b1;
            vec_q <= next_vec;
            mem_req <= '{cyc: 1'b1, we: 1'b1, adr: stp + 32'h0000_0001, dat: pc};
            state <= ST_WR;
          end else if (take_cmd) begin
            entry_q <= 1'b0;
            op_q <= cmd_op;
            idx_q <= cmd_idx;
            if (cmd_push) begin
              mem_req.cyc <= 1'b1;
              mem_req.we <= 1'b1;
              mem_req.adr <= stp + 32'h0000_0001;
              if (cmd_op == OP_PUSH_INT) begin
                mem_req.dat <= ext[cmd_idx][31:0];
              end else if (cmd_op == OP_PUSH_FLT) begin
                mem_req.dat <= ext[cmd_idx][39:8];
              end else begin
                mem_req.dat <= pc + 32'h0000_0001;
              end
              state <= ST_WR;
            end else if (cmd_pop) begin
              mem_req <= '{cyc: 1'b1, we: 1'b0, adr: stp, dat: 32'h0000_0000};
              state <= ST_RD;
            end
          end
        end
        ST_WR: begin
          if (mem_ack) begin
            if (entry_q) begin
              mem_req <= '{cyc: 1'b1, we: 1'b0, adr: vtp + vec_q, dat: 32'h0000_0000};
              state <= ST_VEC;
            end else begin
              mem_req.cyc <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_RD, ST_VEC: begin
          if (mem_ack) begin
            mem_req.cyc <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          mem_req <= '0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // stack pointer deliberately has no reset
  always_ff @(posedge clk) begin
    if (take_irq || (take_cmd && cmd_push)) begin
      stp <= stp + 32'h0000_0001;
    end else if (rd_done) begin
      stp <= stp - 32'h0000_0001;
    end else if (bus_wr && wb_adr_i == A_STP) begin
      stp <= merge(stp, wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // program counter and status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= 32'h0000_0000;
    end else if (vec_done) begin
      pc <= mem_rdata;
    end else if (rd_done && (op_q == OP_RET || op_q == OP_RETI)) begin
      pc <= mem_rdata;
    end else if (take_cmd && cmd_op == OP_CALL) begin
      pc <= arg;
    end else if (bus_wr && wb_adr_i == A_PC) begin
      pc <= merge(pc, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_irq_enable <= 1'b0;
      cache_freeze <= 1'b0;
      prior_global_irq_enable <= 1'b0;
      prior_cache_freeze <= 1'b0;
    end else if (take_irq) begin
      prior_global_irq_enable <= global_irq_enable;
      prior_cache_freeze <= cache_freeze;
      global_irq_enable <= 1'b0;
    end else if (rd_done && op_q == OP_RETI) begin
      global_irq_enable <= prior_global_irq_enable;
      cache_freeze <= prior_cache_freeze;
    end else if (bus_wr && wb_adr_i == A_STATUS && wb_sel_i[0]) begin
      global_irq_enable <= wb_dat_i[SB_IRQ_EN];
      cache_freeze <= wb_dat_i[SB_FREEZE];
      prior_global_irq_enable <= wb_dat_i[SB_PRIOR_EN];
      prior_cache_freeze <= wb_dat_i[SB_PRIOR_FREEZE];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vtp <= 32'h0000_0000;
      irq_en <= '0;
      arg <= 32'h0000_0000;
      int_mask <= 3'h0;
    end else if (bus_wr) begin
      case (wb_adr_i)
        A_VTP: vtp <= merge(vtp, wb_dat_i, wb_sel_i);
        A_IRQ_EN: irq_en <= wb_sel_i[0] ? wb_dat_i[NUM_IRQ-1:0] : irq_en;
        A_ARG: arg <= merge(arg, wb_dat_i, wb_sel_i);
        A_INT_MASK: int_mask <= wb_sel_i[0] ? wb_dat_i[2:0] : int_mask;
        default: arg <= arg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending interrupt flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= '0;
      nmi_pend <= 1'b0;
    end else begin
      flag <= irq_in | (flag & ~(take_irq ? irq_clr : '0) &
              ~((bus_wr && wb_adr_i == A_IRQ_FLAG && wb_sel_i[0]) ?
                wb_dat_i[NUM_IRQ-1:0] : '0));
      nmi_pend <= nmi_in | (nmi_pend & ~take_irq);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_pend <= 1'b0;
      cmd_q <= 32'h0000_0000;
    end else if (bus_wr && wb_adr_i == A_CMD && !reject) begin
      cmd_pend <= 1'b1;
      cmd_q <= wb_dat_i;
    end else if (take_cmd) begin
      cmd_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register files
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_EXT; i++) begin
        ext[i] <= 40'h00_0000_0000;
      end
    end else if (rd_done && op_q == OP_POP_INT) begin
      ext[idx_q][31:0] <= mem_rdata;
    end else if (rd_done && op_q == OP_POP_FLT) begin
      ext[idx_q] <= {mem_rdata, FLT_LOW_ZERO};
    end else if (bus_wr && wb_adr_i[7:6] == A_EXT_LO_BASE[7:6] && wb_adr_i[5:2] <= EXT_LAST) begin
      ext[wb_adr_i[5:2]][31:0] <= merge(ext[wb_adr_i[5:2]][31:0], wb_dat_i, wb_sel_i);
    end else if (bus_wr && wb_adr_i[7:6] == A_EXT_HI_BASE[7:6] && wb_adr_i[5:2] <= EXT_LAST &&
                 wb_sel_i[0]) begin
      ext[wb_adr_i[5:2]][39:32] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_ea <= 32'h0000_0000;
      for (int i = 0; i < NUM_AUX; i++) begin
        aux[i] <= 32'h0000_0000;
      end
    end else if (take_cmd && cmd_op == OP_AUX) begin
      case (cmd_mode)
        AM_PRE_INC: begin
          aux[cmd_aux] <= aux[cmd_aux] + disp;
          aux_ea <= aux[cmd_aux] + disp;
        end
        AM_PRE_DEC: begin
          aux[cmd_aux] <= aux[cmd_aux] - disp;
          aux_ea <= aux[cmd_aux] - disp;
        end
        AM_POST_INC: begin
          aux[cmd_aux] <= aux[cmd_aux] + disp;
          aux_ea <= aux[cmd_aux];
        end
        default: begin
          aux[cmd_aux] <= aux[cmd_aux] - disp;
          aux_ea <= aux[cmd_aux];
        end
      endcase
    end else if (bus_wr && wb_adr_i[7:5] == A_AUX_BASE[7:5]) begin
      aux[wb_adr_i[4:2]] <= merge(aux[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // events, interrupt, bus answer
  // ----------------------------------------------------------------
  logic [2:0] ev;
  assign ev[EV_DONE] = (take_cmd & ~cmd_push & ~cmd_pop) | (wr_done & ~entry_q) |
                       rd_done | vec_done;
  assign ev[EV_IRQ] = take_irq;
  assign ev[EV_ERR] = reject | (take_cmd & cmd_bad);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_stat <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      int_stat <= ev | (int_stat & ~((bus_wr && wb_adr_i == A_INT_STAT && wb_sel_i[0]) ?
                  wb_dat_i[2:0] : 3'h0));
      irq_o <= |(int_stat & int_mask);
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      A_STP: rd_mux = stp;
      A_VTP: rd_mux = vtp;
      A_PC: rd_mux = pc;
      A_STATUS: rd_mux = {28'h000_0000, prior_cache_freeze, prior_global_irq_enable,
                          cache_freeze, global_irq_enable};
      A_IRQ_FLAG: rd_mux = {28'h000_0000, flag};
      A_IRQ_EN: rd_mux = {28'h000_0000, irq_en};
      A_CMD: rd_mux = {30'h0000_0000, ~idle, cmd_pend};
      A_ARG: rd_mux = arg;
      A_AUX_EA: rd_mux = aux_ea;
      A_INT_STAT: rd_mux = {29'h0000_0000, int_stat};
      A_INT_MASK: rd_mux = {29'h0000_0000, int_mask};
      default: begin
        if (wb_adr_i[7:5] == A_AUX_BASE[7:5]) begin
          rd_mux = aux[wb_adr_i[4:2]];
        end else if (wb_adr_i[7:6] == A_EXT_LO_BASE[7:6] && wb_adr_i[5:2] <= EXT_LAST) begin
          rd_mux = ext[wb_adr_i[5:2]][31:0];
        end else if (wb_adr_i[7:6] == A_EXT_HI_BASE[7:6] && wb_adr_i[5:2] <= EXT_LAST) begin
          rd_mux = {24'h00_0000, ext[wb_adr_i[5:2]][39:32]};
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PUSH_PREINC: assert property (@(posedge clk) disable iff (sys_rst)
    take_cmd && cmd_push |=> stp == $past(stp) + 32'h0000_0001 && mem_req.adr == stp)
    else $error("push did not pre-increment the stack pointer");
  AST_POP_POSTDEC: assert property (@(posedge clk) disable iff (sys_rst)
    rd_done |-> (mem_req.adr == stp) ##1 (stp == $past(stp) - 32'h0000_0001))
    else $error("pop did not post-decrement the stack pointer");
  AST_ENTRY_PRIOR: assert property (@(posedge clk) disable iff (sys_rst)
    take_irq |=> !global_irq_enable && prior_global_irq_enable == $past(global_irq_enable) &&
    prior_cache_freeze == $past(cache_freeze))
    else $error("entry did not save and clear enables");
  AST_ENTRY_PUSH_PC: assert property (@(posedge clk) disable iff (sys_rst)
    take_irq |=> mem_req.cyc && mem_req.we && mem_req.dat == $past(pc) &&
    mem_req.adr == $past(stp) + 32'h0000_0001)
    else $error("entry did not push the program counter");
  AST_VEC_FETCH: assert property (@(posedge clk) disable iff (sys_rst)
    wr_done && entry_q |=> state == ST_VEC && mem_req.adr == $past(vtp) + $past(vec_q) &&
    !mem_req.we)
    else $error("vector fetch address wrong");
  AST_MASK_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    !global_irq_enable && !nmi_pend |-> !take_irq)
    else $error("maskable interrupt taken while disabled");
  AST_FLT_POP_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    rd_done && op_q == OP_POP_FLT |=> ext[$past(idx_q)] == {$past(mem_rdata), FLT_LOW_ZERO})
    else $error("float pop did not clear low bits");
  AST_RETI_RESTORE: assert property (@(posedge clk) disable iff (sys_rst)
    rd_done && op_q == OP_RETI |=> global_irq_enable == $past(prior_global_irq_enable) &&
    cache_freeze == $past(prior_cache_freeze) &&
    pc == $past(mem_rdata))
    else $error("conditional return did not restore state");
  AST_FLAG_POLL: assert property (@(posedge clk) disable iff (sys_rst)
    irq_in != '0 |=> (flag & $past(irq_in)) == $past(irq_in))
    else $error("interrupt event lost from flag register");
endmodule

// file: inc/sie_pkg.sv
package sie_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_STP = 8'h00;
  localparam logic [7:0] A_VTP = 8'h04;
  localparam logic [7:0] A_PC = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0C;
  localparam logic [7:0] A_IRQ_FLAG = 8'h10;
  localparam logic [7:0] A_IRQ_EN = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  localparam logic [7:0] A_ARG = 8'h1C;
  localparam logic [7:0] A_AUX_EA = 8'h20;
  localparam logic [7:0] A_INT_STAT = 8'h24;
  localparam logic [7:0] A_INT_MASK = 8'h28;
  localparam logic [7:0] A_AUX_BASE = 8'h40;
  localparam logic [7:0] A_EXT_LO_BASE = 8'h80;
  localparam logic [7:0] A_EXT_HI_BASE = 8'hC0;
  // ----------------------------------------------------------------
  // sizes, fields, codes
  // ----------------------------------------------------------------
  localparam int NUM_EXT = 12;
  localparam int NUM_AUX = 8;
  localparam int NUM_IRQ = 4;
  localparam logic [3:0] EXT_LAST = 4'h0B;
  localparam int SB_IRQ_EN = 0;
  localparam int SB_FREEZE = 1;
  localparam int SB_PRIOR_EN = 2;
  localparam int SB_PRIOR_FREEZE = 3;
  localparam int EV_DONE = 0;
  localparam int EV_IRQ = 1;
  localparam int EV_ERR = 2;
  localparam int CMD_COND = 8;
  localparam logic [31:0] VEC_NMI = 32'h0000_0001;
  localparam logic [31:0] VEC_IRQ_BASE = 32'h0000_0002;
  localparam logic [7:0] FLT_LOW_ZERO = 8'h00;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PUSH_INT = 4'h1,
    OP_PUSH_FLT = 4'h2,
    OP_POP_INT = 4'h3,
    OP_POP_FLT = 4'h4,
    OP_CALL = 4'h5,
    OP_RET = 4'h6,
    OP_RETI = 4'h7,
    OP_AUX = 4'h8
  } sie_op_t;
  typedef enum logic [1:0] {
    AM_PRE_INC = 2'h0,
    AM_PRE_DEC = 2'h1,
    AM_POST_INC = 2'h2,
    AM_POST_DEC = 2'h3
  } sie_amode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WR = 4'b0010,
    ST_RD = 4'b0100,
    ST_VEC = 4'b1000
  } sie_state_t;
  typedef struct packed {
    logic cyc;
    logic we;
    logic [31:0] adr;
    logic [31:0] dat;
  } sie_mem_req_t;
endpackage

// file: tb/sie_mem_model.sv
`timescale 1ns/1ps
module sie_mem_model (
  input wire logic clk, // core clock
  input wire logic sys_rst, // async reset, high
  input wire logic [3:0] slow, // wait cycles before each ack
  input wire sie_pkg::sie_mem_req_t mem_req, // request from the core
  output logic [31:0] mem_rdata, // read data, valid with ack
  output logic mem_ack // one-cycle acknowledge
);
  import sie_pkg::*;
  logic [31:0] mem [0:1023];
  logic [3:0] wait_cnt;
  // ----------------------------------------------------------------
  // storage, every word preloaded with 32'h0000_A000 plus its index
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 1024; k++) begin
      mem[k] = 32'h0000_A000 + k;
    end
  end
  // ----------------------------------------------------------------
  // one access at a time; data line toggles when not acking
  // ----------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= 32'h5A5A_5A5A;
    end else if (mem_ack || !mem_req.cyc) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_cnt < slow) begin
      wait_cnt <= wait_cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      if (mem_req.we) begin
        mem[mem_req.adr[9:0]] <= mem_req.dat;
      end
      mem_rdata <= mem[mem_req.adr[9:0]];
    end
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sie_pkg::*;
  logic clk, sys_rst, cyc, stb, we, ack, nmi_in, irq_o, mem_ack;
  logic [7:0] adr;
  logic [3:0] sel, irq_in, slow;
  logic [31:0] wdat, dat_o, mem_rdata, rd;
  sie_mem_req_t mem_req;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  sie_core dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_in(irq_in),
    .nmi_in(nmi_in), .irq_o(irq_o));
  sie_mem_model mem_m (.clk(clk), .sys_rst(sys_rst), .slow(slow), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask
  task automatic chkreg(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, rd);
    chk(nm, rd, exp);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    do wb(1'b0, a, 32'h0, rd); while ((rd & m) !== v);
  endtask
  task automatic run(input logic [31:0] c);
    wr(A_CMD, c);
    poll(A_INT_STAT, 32'h1, 32'h1);
    wr(A_INT_STAT, 32'h1);
  endtask
  task automatic entry();
    poll(A_INT_STAT, 32'h2, 32'h2);
    poll(A_CMD, 32'h3, 32'h0);
  endtask
  task automatic pulse(input logic [3:0] m, input logic n);
    @(posedge clk);
    irq_in <= m;
    nmi_in <= n;
    @(posedge clk);
    irq_in <= 4'h0;
    nmi_in <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input sie_op_t op, input logic [3:0] idx);
    return {24'h0, idx, op};
  endfunction
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {cyc, stb, we, nmi_in} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    irq_in = 4'h0;
    slow = 4'h3;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    chkreg("status", A_STATUS, 32'h0);
    chkreg("unmapped", 8'h30, 32'h0);
    wr(A_STP, 32'h0000_0100);
    chkreg("stp", A_STP, 32'h0000_0100);
    $display("test reset done");
    wr(A_EXT_LO_BASE + 8'd44, 32'h1234_5678);
    wr(A_EXT_HI_BASE + 8'd44, 32'h0000_00AB);
    wr(A_CMD, cw(OP_PUSH_INT, EXT_LAST));
    wr(A_CMD, cw(OP_PUSH_INT, EXT_LAST));
    poll(A_INT_STAT, 32'h5, 32'h5);
    wr(A_INT_STAT, 32'h7);
    chkreg("one push", A_STP, 32'h0000_0101);
    run(cw(OP_POP_INT, 4'h1));
    chkreg("pop int", A_EXT_LO_BASE + 8'd4, 32'h1234_5678);
    run(cw(OP_PUSH_INT, EXT_LAST));
    chk("push int", mem_m.mem[10'h101], 32'h1234_5678);
    run(cw(OP_PUSH_FLT, EXT_LAST));
    chk("push flt", mem_m.mem[10'h102], 32'hAB12_3456);
    chkreg("stp up", A_STP, 32'h0000_0102);
    run(cw(OP_POP_FLT, 4'h0));
    chkreg("flt lo", A_EXT_LO_BASE, 32'h1234_5600);
    chkreg("flt hi", A_EXT_HI_BASE, 32'h0000_00AB);
    run(cw(OP_POP_INT, 4'h0));
    chkreg("int lo", A_EXT_LO_BASE, 32'h1234_5678);
    chkreg("stp down", A_STP, 32'h0000_0100);
    wr(A_CMD, cw(OP_POP_INT, 4'hC));
    poll(A_INT_STAT, 32'h5, 32'h5);
    wr(A_INT_STAT, 32'h7);
    chkreg("bad idx stp", A_STP, 32'h0000_0100);
    $display("test push pop done");
    wr(A_PC, 32'h0000_0030);
    wr(A_ARG, 32'h0000_0055);
    run(cw(OP_CALL, 4'h0));
    chk("call push", mem_m.mem[10'h101], 32'h0000_0031);
    chkreg("call pc", A_PC, 32'h0000_0055);
    run(cw(OP_RET, 4'h0));
    chkreg("ret pc", A_PC, 32'h0000_0031);
    chkreg("ret stp", A_STP, 32'h0000_0100);
    $display("test call done");
    slow <= 4'h0;
    wr(A_VTP, 32'h0000_0200);
    wr(A_IRQ_EN, 32'h0000_000F);
    pulse(4'h4, 1'b0);
    chkreg("flag poll", A_IRQ_FLAG, 32'h4);
    chkreg("no entry", A_PC, 32'h0000_0031);
    wr(A_STATUS, 32'h3);
    entry();
    chkreg("irq pc", A_PC, 32'h0000_A204);
    chk("irq push", mem_m.mem[10'h101], 32'h0000_0031);
    chkreg("irq status", A_STATUS, 32'hE);
    chk("masked irq_o", irq_o, 1'b0);
    wr(A_INT_MASK, 32'h2);
    chkreg("irq flag", A_IRQ_FLAG, 32'h0);
    chk("irq_o", irq_o, 1'b1);
    wr(A_INT_STAT, 32'h7);
    wr(A_VTP, 32'h0);
    chk("irq_o clr", irq_o, 1'b0);
    pulse(4'h1, 1'b1);
    entry();
    chkreg("nmi pc", A_PC, 32'h0000_A001);
    chkreg("held flag", A_IRQ_FLAG, 32'h1);
    wr(A_INT_STAT, 32'h7);
    run(cw(OP_RETI, 4'h0));
    chkreg("no return", A_PC, 32'h0000_A001);
    wr(A_STATUS, 32'h4);
    wr(A_CMD, cw(OP_RETI, 4'h0) | 32'h100);
    poll(A_INT_STAT, 32'h3, 32'h3);
    poll(A_CMD, 32'h3, 32'h0);
    chk("reti pop", mem_m.mem[10'h102], 32'h0000_A204);
    chkreg("reenabled pc", A_PC, 32'h0000_A002);
    chkreg("reti status", A_STATUS, 32'h4);
    wr(A_INT_STAT, 32'h7);
    wr(A_INT_MASK, 32'h0);
    $display("test interrupts done");
    for (int m = 0; m < 4; m++) begin
      wr(A_AUX_BASE + 8'd12, 32'h40);
      run({8'h0, 8'h01, 1'b0, 3'd3, 1'b0, 2'(m), 1'b0, 4'h0, OP_AUX});
      chkreg("aux ea", A_AUX_EA, (m == 0) ? 32'h41 : (m == 1) ? 32'h3F : 32'h40);
      chkreg("aux reg", A_AUX_BASE + 8'd12, (m[0] == 1'b0) ? 32'h41 : 32'h3F);
    end
    $display("test aux done");
    complete_run();
  end
endmodule
